/* rtl/hppc_defines.vh */
// Constants for the host port pin configuration block
// Function
// - Device raises receive-data-full whenever receive bytes hold data for the host.
// - Device flags transmit bytes empty and moves them into the core-side register.
// - Every pin function follows the 16-bit port control register.
// - Host mode, non-multiplexed: eight pins are bidirectional data lines 0 to 7.
// - Host mode, multiplexed: same eight pins are shared address/data lines 0 to 7.
// - GPIO mode: each pin is input or output per its direction bit.
// - Non-multiplexed host mode: three input pins are host address lines 0, 1, 2.
// - Multiplexed host mode: address pins one and two become address lines 8, 9.
// - Multiplexed mode: address-0 pin is address strobe, polarity programmable, reset active-low.
`ifndef HPPC_DEFINES_VH
`define HPPC_DEFINES_VH
// Avalon byte offsets
`define HPPC_OFS_PCTL     6'h00
`define HPPC_OFS_PDIR     6'h04
`define HPPC_OFS_GPO      6'h08
`define HPPC_OFS_GPI      6'h0c
`define HPPC_OFS_RXWORD   6'h10
`define HPPC_OFS_CORERX   6'h14
`define HPPC_OFS_STATUS   6'h18
`define HPPC_OFS_HVEC     6'h1c
// Port control register fields
`define HPPC_PCTL_HIEN    0
`define HPPC_PCTL_MUX     1
`define HPPC_PCTL_ASPOL   2
`define HPPC_PCTL_RST     16'h0000
// Host side register selects
`define HPPC_HA_STATUS    3'h0
`define HPPC_HA_VEC       3'h1
`define HPPC_HA_HIGH      3'h5
`define HPPC_HA_MID       3'h6
`define HPPC_HA_LOW       3'h7
// Host vector register
`define HPPC_HV_CMD       7
`define HPPC_HV_RST       8'h00
// Status fields
`define HPPC_ST_RECEIVE_DATA_FULL_FLAG      0
`define HPPC_ST_TRANSMIT_DATA_EMPTY_FLAG      1
`define HPPC_ST_HC        2
`define HPPC_CORERX_VALID 24
`endif

/* rtl/hppc_top.v */
// Host port pin configuration: pin muxing, host byte registers and Avalon slave
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`include "hppc_defines.vh"

module hppc_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             srst,
    // Fill side
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    // Drain side
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready,
    // Fill level
    output wire [AW:0]      count
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      cnt_reg;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_reg != DEPTH[AW:0]);
    assign out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign out_data  = mem_reg[rd_ptr_reg];
    assign count     = cnt_reg;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            cnt_reg    <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                              : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                              : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end
endmodule // hppc_fifo

module hppc_top #(
    parameter NPINS = 11,
    parameter FDEPTH = 32,
    parameter FAW    = 5
) (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        srst,
    // Avalon-MM slave
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Data / muxed address-data / gpio_low_pins
    input  wire [7:0]  data_pin_in,
    output wire [7:0]  data_pin_out,
    output wire [7:0]  data_pin_oe,
    // Address line zero / address strobe / gpio pin eight
    input  wire        pin8_in,
    output wire        pin8_out,
    output wire        pin8_oe,
    // Address line one / muxed address line eight / gpio pin nine
    input  wire        pin9_in,
    output wire        pin9_out,
    output wire        pin9_oe,
    // Address line two / muxed address line nine / gpio pin ten
    input  wire        pin10_in,
    output wire        pin10_out,
    output wire        pin10_oe,
    // Host access strobes, active high
    input  wire        host_rd,
    input  wire        host_wr
);
    // Avalon side
    reg [31:0]      readdata_reg;
    reg [31:0]      readdata_next;
    reg             wait_reg;
    // Configuration
    reg [15:0]      port_control_register;
    reg [NPINS-1:0] port_direction_register;
    reg [NPINS-1:0] gpio_out_reg;
    // Host byte registers
    reg [7:0]       receive_byte_high;
    reg [7:0]       receive_byte_middle;
    reg [7:0]       receive_byte_low;
    reg             receive_data_full_flag;
    reg [7:0]       transmit_byte_high;
    reg [7:0]       transmit_byte_middle;
    reg [7:0]       transmit_byte_low;
    reg             tx_pend_reg;
    reg [7:0]       host_vector_register;
    // Host strobes and address
    reg             rd_prev_reg;
    reg             wr_prev_reg;
    reg [9:0]       mux_addr_reg;
    // Pin drivers
    reg [NPINS-1:0] pin_out_reg;
    reg [NPINS-1:0] pin_oe_reg;
    reg [NPINS-1:0] pin_out_next;
    reg [NPINS-1:0] pin_oe_next;
    reg [7:0]       host_rdata;
    // FIFO
    wire [23:0]     core_side_receive_register;
    wire            fifo_in_ready;
    wire            fifo_out_valid;
    wire [FAW:0]    fifo_count;

    wire            hi_en;
    wire            muxed;
    wire            strobe_act;
    wire [2:0]      host_sel;
    wire            acc;
    wire            host_wr_edge;
    wire            host_rd_edge;
    wire            core_pop;
    wire            rx_load;
    wire [NPINS-1:0] pin_in;
    wire [31:0]     pctl_wr, pdir_wr, gpo_wr;

    // Byte-lane merge for partial Avalon writes
    function [31:0] be_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0]  be;
        integer i;
        begin
            be_merge = old_val;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    be_merge[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    assign pin_in = {pin10_in, pin9_in, pin8_in, data_pin_in};
    assign pctl_wr = be_merge({16'h0000, port_control_register}, avs_writedata, avs_byteenable);
    assign pdir_wr = be_merge({{(32-NPINS){1'b0}}, port_direction_register}, avs_writedata,
                              avs_byteenable);
    assign gpo_wr = be_merge({{(32-NPINS){1'b0}}, gpio_out_reg}, avs_writedata, avs_byteenable);
    assign hi_en  = port_control_register[`HPPC_PCTL_HIEN];
    assign muxed  = port_control_register[`HPPC_PCTL_MUX];
    // Strobe active level from polarity bit; reset value 0 means active low
    assign strobe_act = port_control_register[`HPPC_PCTL_ASPOL] ? pin8_in
                        : !pin8_in;
    // Non-muxed selects from three address pins, muxed from latched address
    assign host_sel = muxed ? mux_addr_reg[2:0]
                      : {pin10_in, pin9_in, pin8_in};
    assign host_wr_edge = hi_en && host_wr && !wr_prev_reg;
    assign host_rd_edge = hi_en && host_rd && !rd_prev_reg;
    // One action per request, taken on the edge that ends the wait
    assign acc     = (avs_read || avs_write) && wait_reg;
    assign core_pop = acc && avs_read && (avs_address == `HPPC_OFS_CORERX);
    assign rx_load  = acc && avs_write && (avs_address == `HPPC_OFS_RXWORD);

    hppc_fifo #(
        .WIDTH (24),
        .DEPTH (FDEPTH),
        .AW    (FAW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .in_data   ({transmit_byte_high, transmit_byte_middle, transmit_byte_low}),
        .in_valid  (tx_pend_reg),
        .in_ready  (fifo_in_ready),
        .out_data  (core_side_receive_register),
        .out_valid (fifo_out_valid),
        .out_ready (core_pop),
        .count     (fifo_count)
    );

    // Host-visible read mux
    always @* begin
        case (host_sel)
            `HPPC_HA_STATUS: host_rdata = {6'h00, !tx_pend_reg, receive_data_full_flag};
            `HPPC_HA_VEC:    host_rdata = host_vector_register;
            `HPPC_HA_HIGH:   host_rdata = receive_byte_high;
            `HPPC_HA_MID:    host_rdata = receive_byte_middle;
            `HPPC_HA_LOW:    host_rdata = receive_byte_low;
            default:         host_rdata = 8'h00;
        endcase
    end

    // Pin function: one role per pin from the current control setting
    always @* begin
        if (hi_en) begin
            pin_out_next = {3'h0, host_rdata};
            pin_oe_next  = {3'h0, {8{host_rd}}};
        end else begin
            pin_out_next = gpio_out_reg;
            pin_oe_next  = port_direction_register;
        end
    end

    // Avalon read mux
    always @* begin
        readdata_next = 32'h0000_0000;
        case (avs_address)
            `HPPC_OFS_PCTL:   readdata_next[15:0] = port_control_register;
            `HPPC_OFS_PDIR:   readdata_next[NPINS-1:0] = port_direction_register;
            `HPPC_OFS_GPO:    readdata_next[NPINS-1:0] = gpio_out_reg;
            `HPPC_OFS_GPI:    readdata_next[NPINS-1:0] = pin_in;
            `HPPC_OFS_RXWORD: readdata_next[23:0] = {receive_byte_high,
                                                     receive_byte_middle,
                                                     receive_byte_low};
            `HPPC_OFS_CORERX: begin
                readdata_next[23:0] = core_side_receive_register;
                readdata_next[`HPPC_CORERX_VALID] = fifo_out_valid;
            end
            `HPPC_OFS_STATUS: begin
                readdata_next[`HPPC_ST_RECEIVE_DATA_FULL_FLAG] = receive_data_full_flag;
                readdata_next[`HPPC_ST_TRANSMIT_DATA_EMPTY_FLAG] = !tx_pend_reg;
                readdata_next[`HPPC_ST_HC]   = host_vector_register[`HPPC_HV_CMD];
                readdata_next[8 +: FAW+1]    = fifo_count;
                readdata_next[25:16]         = mux_addr_reg;
            end
            `HPPC_OFS_HVEC:   readdata_next[7:0] = host_vector_register;
            default:          readdata_next = 32'h0000_0000;
        endcase
    end

    // Avalon slave: waitrequest drops one cycle after the request appears
    always @(posedge sys_clk) begin
        if (srst) begin
            wait_reg     <= 1'b1;
            readdata_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= !acc;
            if (acc && avs_read) begin
                readdata_reg <= readdata_next;
            end
        end
    end

    // Configuration registers
    always @(posedge sys_clk) begin
        if (srst) begin
            port_control_register   <= `HPPC_PCTL_RST;
            port_direction_register <= {NPINS{1'b0}};
            gpio_out_reg            <= {NPINS{1'b0}};
        end else if (acc && avs_write) begin
            case (avs_address)
                `HPPC_OFS_PCTL: port_control_register   <= pctl_wr[15:0];
                `HPPC_OFS_PDIR: port_direction_register <= pdir_wr[NPINS-1:0];
                `HPPC_OFS_GPO:  gpio_out_reg            <= gpo_wr[NPINS-1:0];
                default: ;
            endcase
        end
    end

    // Host strobes, muxed address latch and pin drivers
    always @(posedge sys_clk) begin
        if (srst) begin
            rd_prev_reg  <= 1'b0;
            wr_prev_reg  <= 1'b0;
            mux_addr_reg <= 10'h000;
            pin_out_reg  <= {NPINS{1'b0}};
            pin_oe_reg   <= {NPINS{1'b0}};
        end else begin
            rd_prev_reg <= host_rd;
            wr_prev_reg <= host_wr;
            if (hi_en && muxed && strobe_act) begin
                mux_addr_reg <= {pin10_in, pin9_in, data_pin_in};
            end
            pin_out_reg <= pin_out_next;
            pin_oe_reg  <= pin_oe_next;
        end
    end

    // Receive bytes: core loads a word, host reading the low byte empties it
    always @(posedge sys_clk) begin
        if (srst) begin
            receive_byte_high      <= 8'h00;
            receive_byte_middle    <= 8'h00;
            receive_byte_low       <= 8'h00;
            receive_data_full_flag <= 1'b0;
        end else begin
            if (rx_load) begin
                receive_byte_high   <= avs_writedata[23:16];
                receive_byte_middle <= avs_writedata[15:8];
                receive_byte_low    <= avs_writedata[7:0];
            end
            // A load in the same cycle as the host read keeps the flag set
            if (rx_load) begin
                receive_data_full_flag <= 1'b1;
            end else if (host_rd_edge && host_sel == `HPPC_HA_LOW) begin
                receive_data_full_flag <= 1'b0;
            end
        end
    end

    // Transmit bytes: low byte completes a word, which moves to the FIFO
    always @(posedge sys_clk) begin
        if (srst) begin
            transmit_byte_high   <= 8'h00;
            transmit_byte_middle <= 8'h00;
            transmit_byte_low    <= 8'h00;
            tx_pend_reg          <= 1'b0;
        end else begin
            // Writes while a word waits are dropped; the host is to check empty first
            if (host_wr_edge && !tx_pend_reg) begin
                case (host_sel)
                    `HPPC_HA_HIGH: transmit_byte_high   <= data_pin_in;
                    `HPPC_HA_MID:  transmit_byte_middle <= data_pin_in;
                    `HPPC_HA_LOW:  transmit_byte_low    <= data_pin_in;
                    default: ;
                endcase
            end
            if (host_wr_edge && !tx_pend_reg && host_sel == `HPPC_HA_LOW) begin
                tx_pend_reg <= 1'b1;
            end else if (tx_pend_reg && fifo_in_ready) begin
                tx_pend_reg <= 1'b0;
            end
        end
    end

    // Host vector: host sets command, core clears it by writing one to bit 7
    always @(posedge sys_clk) begin
        if (srst) begin
            host_vector_register <= `HPPC_HV_RST;
        end else if (host_wr_edge && host_sel == `HPPC_HA_VEC
                     && !host_vector_register[`HPPC_HV_CMD]) begin
            // Set wins over a core clear; a refused host write leaves the clear alone
            host_vector_register <= data_pin_in;
        end else if (acc && avs_write && avs_address == `HPPC_OFS_HVEC
                     && avs_byteenable[0] && avs_writedata[`HPPC_HV_CMD]) begin
            host_vector_register[`HPPC_HV_CMD] <= 1'b0;
        end
    end

    assign avs_readdata    = readdata_reg;
    assign avs_waitrequest = wait_reg;
    assign data_pin_out    = pin_out_reg[7:0];
    assign data_pin_oe     = pin_oe_reg[7:0];
    assign pin8_out        = pin_out_reg[8];
    assign pin8_oe         = pin_oe_reg[8];
    assign pin9_out        = pin_out_reg[9];
    assign pin9_oe         = pin_oe_reg[9];
    assign pin10_out       = pin_out_reg[10];
    assign pin10_oe        = pin_oe_reg[10];
endmodule // hppc_top

/* testbench/hppc_top_asserts.sv */
// Port-level checker for the host port pin configuration block
`timescale 1ns/1ps
module hppc_top_asserts #(
    parameter NPINS  = 11,
    parameter FDEPTH = 32,
    parameter FAW    = 5
) (
    // Clock and reset
    input wire        sys_clk,
    input wire        srst,
    // Avalon-MM slave
    input wire [5:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    // Pins
    input wire [7:0]  data_pin_in,
    input wire [7:0]  data_pin_out,
    input wire [7:0]  data_pin_oe,
    input wire        pin8_in,
    input wire        pin8_out,
    input wire        pin8_oe,
    input wire        pin9_in,
    input wire        pin9_out,
    input wire        pin9_oe,
    input wire        pin10_in,
    input wire        pin10_out,
    input wire        pin10_oe,
    // Host strobes
    input wire        host_rd,
    input wire        host_wr
);
    logic [2:0]  pctl_reg;
    logic [10:0] pdir_reg;
    logic [1:0]  age_reg;
    wire         done_wr = avs_write && !avs_waitrequest;
    // Pin checks wait until the configuration has been still for three cycles
    wire         hi_ok = age_reg == 2'h3 && pctl_reg[0];
    wire         gp_ok = age_reg == 2'h3 && !pctl_reg[0];
    always @(posedge sys_clk) begin
        if (srst) begin
            pctl_reg <= 3'h0;
            pdir_reg <= 11'h000;
            age_reg  <= 2'h0;
        end else begin
            if (done_wr && avs_address == 6'h00 && avs_byteenable[0])
                pctl_reg <= avs_writedata[2:0];
            if (done_wr && avs_address == 6'h04)
                pdir_reg <= avs_writedata[10:0];
            if (done_wr && avs_address[5:3] == 3'h0)
                age_reg <= 2'h0;
            else if (age_reg != 2'h3)
                age_reg <= age_reg + 2'h1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_req_seen;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_rd_held;
        hi_ok && host_rd ##1 host_rd;
    endsequence
    property p_wait_one;
        s_req_seen |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one)
        else $error("request not answered after one wait cycle");
    property p_wait_pulse;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse)
        else $error("waitrequest low for more than one cycle");
    property p_reset_quiet;
        disable iff (1'b0) srst |=> data_pin_oe == 8'h00 && !pin8_oe && !pin9_oe && !pin10_oe;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("pin driven during reset");
    property p_addr_in;
        hi_ok |-> !pin8_oe && !pin9_oe && !pin10_oe;
    endproperty
    a_addr_in: assert property (p_addr_in)
        else $error("address pin driven in host mode");
    property p_data_hiz;
        hi_ok && !host_rd && !$past(host_rd) |-> data_pin_oe == 8'h00;
    endproperty
    a_data_hiz: assert property (p_data_hiz)
        else $error("data pins driven without host read");
    property p_data_drive;
        s_rd_held |-> data_pin_oe == 8'hff;
    endproperty
    a_data_drive: assert property (p_data_drive)
        else $error("data pins not driven during host read");
    property p_gpio_dir;
        gp_ok |-> {pin10_oe, pin9_oe, pin8_oe, data_pin_oe} == pdir_reg;
    endproperty
    a_gpio_dir: assert property (p_gpio_dir)
        else $error("pin enables differ from direction register");
    property p_unmapped;
        avs_read && !avs_waitrequest && avs_address[5] |-> avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned nonzero");
endmodule // hppc_top_asserts

bind hppc_top hppc_top_asserts #(.NPINS(NPINS), .FDEPTH(FDEPTH), .FAW(FAW)) chk_u (.*);

/* testbench/hppc_host_model.sv */
// Host processor model on the far side of the host port pins
`timescale 1ns/1ps
module hppc_host_model (
    // Clock and bus mode
    input  wire        sys_clk,
    input  wire        muxed,
    input  wire        as_high,
    // Device side of pins 10 down to 0
    input  wire [10:0] pin_out,
    input  wire [10:0] pin_oe,
    // Resolved levels and strobes
    output wire [10:0] pin_lvl,
    output logic       host_rd,
    output logic       host_wr
);
    logic [10:0] host_val = 11'h000;
    // No pulls on these pins: a released line shows the level the host model holds in host_val
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & host_val);
    initial begin
        host_rd = 1'b0;
        host_wr = 1'b0;
    end
    task automatic set_pins(input logic [10:0] v);
        host_val <= v;
    endtask
    task automatic access(input bit wr, input logic [2:0] sel, input logic [7:0] wd,
                          output logic [7:0] rv);
        @(posedge sys_clk);
        if (muxed) begin
            host_val <= {2'b10, as_high, 5'h00, sel};
            repeat (2) @(posedge sys_clk);
            host_val <= {2'b10, !as_high, wr ? wd : 3'h7 ^ {5'h1f, ~sel}};
        end else
            host_val <= {sel, wr ? wd : ~host_val[7:0]};
        @(posedge sys_clk);
        host_wr <= wr;
        host_rd <= !wr;
        repeat (2) @(posedge sys_clk);
        rv = pin_lvl[7:0];
        host_wr <= 1'b0;
        host_rd <= 1'b0;
        host_val[7:0] <= ~host_val[7:0];
    endtask
    task automatic wait_flag(input logic [2:0] sel, input int bitn, input logic want);
        logic [7:0] s;
        do begin
            access(1'b0, sel, 8'h00, s);
        end while (s[bitn] !== want);
    endtask
    task automatic send_word(input logic [23:0] w);
        logic [7:0] d;
        wait_flag(3'h0, 1, 1'b1);
        access(1'b1, 3'h5, w[23:16], d);
        access(1'b1, 3'h6, w[15:8], d);
        access(1'b1, 3'h7, w[7:0], d);
    endtask
    task automatic recv_word(output logic [23:0] w);
        wait_flag(3'h0, 0, 1'b1);
        access(1'b0, 3'h5, 8'h00, w[23:16]);
        access(1'b0, 3'h6, 8'h00, w[15:8]);
        access(1'b0, 3'h7, 8'h00, w[7:0]);
    endtask
    task automatic send_vec(input logic [7:0] v);
        logic [7:0] d;
        wait_flag(3'h1, 7, 1'b0);
        access(1'b1, 3'h1, v, d);
    endtask
endmodule // hppc_host_model

/* testbench/test_hppc_top.sv */
// Self-checking bench for the host port pin configuration block
`timescale 1ns/1ps
module test_hppc_top;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hf;
    logic        muxed = 1'b0;
    logic        as_high = 1'b0;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest, host_rd, host_wr, pin8_in, pin9_in, pin10_in;
    wire         pin8_out, pin8_oe, pin9_out, pin9_oe, pin10_out, pin10_oe;
    wire  [7:0]  data_pin_in, data_pin_out, data_pin_oe;
    int          fails = 0;
    int          comparisons = 0;
    logic [31:0] rd, dir, gpo, pins;
    logic [23:0] w, got;
    logic [23:0] q[$];
    logic [2:0]  cfgs[3] = '{3'h1, 3'h3, 3'h7};
    hppc_top dut_u (.sys_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .data_pin_in, .data_pin_out,
        .data_pin_oe, .pin8_in, .pin8_out, .pin8_oe, .pin9_in, .pin9_out, .pin9_oe,
        .pin10_in, .pin10_out, .pin10_oe, .host_rd, .host_wr);
    hppc_host_model host_u (.sys_clk, .muxed, .as_high, .host_rd, .host_wr,
        .pin_out({pin10_out, pin9_out, pin8_out, data_pin_out}),
        .pin_oe({pin10_oe, pin9_oe, pin8_oe, data_pin_oe}),
        .pin_lvl({pin10_in, pin9_in, pin8_in, data_pin_in}));
    initial forever #2 sys_clk = ~sys_clk;
    function automatic [31:0] lvl(input [10:0] d, input [10:0] o, input [10:0] h);
        return {21'h0, (d & o) | (~d & h)};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic av(input bit wr, input [5:0] a, input [31:0] d, output [31:0] r);
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic reset_check();
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        check("oe in reset", {pin10_oe, pin9_oe, pin8_oe, data_pin_oe}, 32'h0);
        av(0, 6'h00, 0, rd);
        check("pctl reset", rd, 32'h0);
    endtask
    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        rd = $urandom(32'h0da9);
        reset_check();
        av(1, 6'h24, $urandom, rd);
        av(0, 6'h24, 0, rd);
        check("unmapped", rd, 32'h0);
        for (int i = 0; i < 4; i++) begin
            dir = $urandom & 32'h7ff;
            gpo = $urandom & 32'h7ff;
            pins = $urandom & 32'h7ff;
            host_u.set_pins(pins[10:0]);
            av(1, 6'h04, dir, rd);
            av(0, 6'h04, 0, rd);
            check("pdir", rd, dir);
            av(1, 6'h08, gpo, rd);
            repeat (3) @(posedge sys_clk);
            check("gpo", {pin10_out, pin9_out, pin8_out, data_pin_out} & dir, gpo & dir);
            av(0, 6'h0c, 0, rd);
            check("gpi", rd, lvl(dir, gpo, pins));
        end
        avs_byteenable <= 4'he;
        av(1, 6'h08, 32'h0, rd);
        avs_byteenable <= 4'hf;
        av(0, 6'h08, 0, rd);
        check("gpo lanes", rd, {24'h0, gpo[7:0]});
        av(1, 6'h04, 0, rd);
        // Strobes are ignored in GPIO mode, so this low-byte write completes nothing
        host_u.access(1'b1, 3'h7, 8'($urandom), got[7:0]);
        av(0, 6'h18, 0, rd);
        check("strobes in gpio", rd[13:0], 14'h2);
        foreach (cfgs[i]) begin
            av(1, 6'h00, cfgs[i], rd);
            muxed <= cfgs[i][1];
            as_high <= cfgs[i][2];
            w = 24'($urandom);
            host_u.send_word(w);
            av(0, 6'h14, 0, rd);
            check("core rx", rd, {8'h01, w});
            w = 24'($urandom);
            av(1, 6'h10, w, rd);
            host_u.recv_word(got);
            check("rx word", got, w);
            av(0, 6'h18, 0, rd);
            check("rx flag", rd[0], 1'b0);
            if (muxed)
                check("latched addr", rd[25:16], 10'h207);
        end
        w[7:0] = 8'h80 | 8'($urandom);
        host_u.send_vec(w[7:0]);
        // Corner case: a vector write while the command is pending must be refused
        host_u.access(1'b1, 3'h1, 8'h00, got[7:0]);
        av(0, 6'h1c, 0, rd);
        check("vector held", rd, {24'h0, w[7:0]});
        av(0, 6'h18, 0, rd);
        check("command set", rd[2], 1'b1);
        av(1, 6'h1c, 32'h80, rd);
        av(0, 6'h18, 0, rd);
        check("command clear", rd[2], 1'b0);
        av(0, 6'h1c, 0, rd);
        check("vector after clear", rd, {25'h0, w[6:0]});
        for (int i = 0; i < 33; i++) begin
            w = 24'($urandom);
            q.push_back(w);
            host_u.send_word(w);
        end
        av(0, 6'h18, 0, rd);
        check("fifo full", {rd[13:8], rd[1]}, {6'd32, 1'b0});
        while (q.size() > 0) begin
            av(0, 6'h14, 0, rd);
            check("drain", rd, {8'h01, q.pop_front()});
        end
        av(0, 6'h14, 0, rd);
        check("empty", rd[24], 1'b0);
        reset_check();
        conclude();
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        fails++;
        conclude();
    end
endmodule // test_hppc_top
